// >>> hdl/sorc_regs.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 32-bit APB words, byte addresses
// Notes:   Definitions only
`ifndef SORC_REGS_SVH
`define SORC_REGS_SVH
`define SORC_REF_CTRL_OFF    12'h000
`define SORC_OSC_CTRL_OFF    12'h004
`define SORC_CONFIG_OFF      12'h008
`define SORC_STATUS_OFF      12'h00C
`define SORC_REF_CTRL_RESET  16'h0000
`define SORC_REF_EN_BIT      15
`define SORC_REF_SLP_BIT     13
`define SORC_REF_SEL_BIT     12
`define SORC_REF_DIV_HI      11
`define SORC_REF_DIV_LO      8
`define SORC_REF_CTRL_WMASK  16'hBF00
`define SORC_FORCE_ON_BIT    1
`define SORC_KEEP_SLP_BIT    2
`define SORC_CFG_HI          9
`define SORC_CFG_LO          8
`define SORC_CFG_RESET       2'h3
`define SORC_STARTUP_US      1000
`define SORC_CLK_MHZ         125
`define SORC_STARTUP_CYCLES  (`SORC_STARTUP_US * `SORC_CLK_MHZ)
`endif

// >>> hdl/sorc_pkg.sv
// Purpose: Types for the secondary oscillator and reference output block
// Assumes: Nothing
// Notes:   Offsets live in sorc_regs.svh
package sorc_pkg;
  typedef enum logic [1:0] {
    SORC_CFG_DIGITAL = 2'h0,
    SORC_CFG_LOWPWR  = 2'h1,
    SORC_CFG_SPARE   = 2'h2,
    SORC_CFG_NORMAL  = 2'h3
  } sorc_cfg_t;
  typedef struct packed {
    logic       psel;
    logic       penable;
    logic       pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } sorc_apb_req_t;
  typedef struct packed {
    logic       osc_enable;
    logic       low_power;
    logic       digital_pins;
    logic       stable;
  } sorc_osc_stat_t;
endpackage : sorc_pkg

// >>> hdl/sorc_sync.sv
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Asynchronous inputs
// Notes:   First stage feeds only the second
`timescale 1ns/1ns
module sorc_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] stage1;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= '0;
      dout   <= '0;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule : sorc_sync

// >>> hdl/sorc_divider.sv
// Purpose: Power-of-two clock divider driven by a sampled source
// Assumes: Source already synchronised, below half of pclk
// Notes:   Code 0 passes the source through
`timescale 1ns/1ns
module sorc_divider #(
  parameter int DW = 16
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       src,
  input  wire logic       run,
  input  wire logic [3:0] code,
  output logic            clk_out
);
  logic          src_d;
  logic [DW-1:0] cnt;
  logic [DW-1:0] next_cnt;
  logic          next_out;
  logic          rise;
  assign rise = src & ~src_d;
  always_comb begin
    next_cnt = cnt;
    next_out = clk_out;
    if (!run) begin
      next_cnt = '0;
      next_out = 1'b0;
    end else if (code == 4'h0) begin
      next_out = src;
    end else if (rise) begin
      // Toggle every 2^(code-1) source edges gives divide by 2^code
      if (cnt >= (DW'(1) << (code - 4'h1)) - DW'(1)) begin
        next_cnt = '0;
        next_out = ~clk_out;
      end else begin
        next_cnt = cnt + DW'(1);
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_d   <= 1'b0;
      cnt     <= '0;
      clk_out <= 1'b0;
    end else begin
      src_d   <= src;
      cnt     <= next_cnt;
      clk_out <= next_out;
    end
  end
endmodule : sorc_divider

// >>> hdl/sorc_top.sv
// Purpose: Secondary oscillator control and reference clock output
// Assumes: Oscillator sources arrive as sampled levels on pins
// Notes:   APB slave, 32-bit data, zero wait states
// Function
// - A peripheral request powers up the secondary oscillator without software
// - Force-on bit starts the secondary oscillator at once
// - Oscillator works only with config codes 11 or 01
// - Config 00 makes the oscillator pins ordinary digital pins
// - Oscillator codes block digital pin use
// - Code 01 selects low drive strength, otherwise high drive
// - Digital mode clocks users from the slow external clock pin
// - Digital mode keeps crystal drive off and ignores force-on
// - Instruction clock output runs at half oscillator rate in some modes
// - Reference output works in every oscillator configuration
// - Enable bit drives the reference clock pin, else pin stays quiet
// - Four-bit divider selects one of sixteen ratios
// - Source select picks primary oscillator when set, system clock when clear
// - Run-in-sleep bit keeps the reference output alive in sleep only with source select set and the keep bit holding the primary oscillator on
// - Sleep without keep bit powers down the primary oscillator
// - With source select clear the output follows system clock switches
//
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ns
`include "sorc_regs.svh"
module sorc_top #(
  parameter int STARTUP_CYCLES = `SORC_STARTUP_CYCLES
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire sorc_pkg::sorc_apb_req_t apb_req,
  output logic                       pready,
  output logic                       pslverr,
  output logic [31:0]                prdata,
  input  wire logic                  periph_osc_req,
  input  wire logic                  secondary_oscillator_clk_in,
  input  wire logic                  slow_ext_clock_in,
  input  wire logic                  primary_osc_clk,
  input  wire logic                  sys_clk_in,
  input  wire logic                  sys_clk_is_secondary_oscillator,
  input  wire logic                  switch_done,
  input  wire logic                  sleep_mode,
  input  wire logic                  fosc_half_mode,
  input  wire logic                  low_power_rc_osc_keep,
  output logic                       secondary_oscillator_crystal_drive,
  output logic                       secondary_oscillator_low_drive,
  output logic                       secondary_oscillator_pins_digital,
  output logic                       periph_osc_clk,
  output logic                       periph_osc_ready,
  output logic                       primary_osc_power,
  output logic                       low_power_rc_osc_power,
  output logic                       instr_clock_out,
  output logic                       ref_clock_pin,
  output logic                       ref_clock_pin_oe
);
  import sorc_pkg::*;

  logic [15:0]    ref_out_control;
  logic [15:0]    next_ref_out_control;
  logic           force_on;
  logic           next_force_on;
  logic           keep_in_sleep;
  logic           next_keep_in_sleep;
  sorc_cfg_t      cfg;
  sorc_cfg_t      next_cfg;
  logic [31:0]    startup_cnt;
  logic [31:0]    next_startup_cnt;
  logic           stable;
  logic           next_stable;
  logic           prev_switch;
  logic           next_prev_switch;
  logic           instr_div;
  logic           next_instr_div;
  logic           periph_clk_q;
  logic           next_periph_clk_q;
  logic [31:0]    next_prdata;
  logic [4:0]     pins_raw;
  logic [4:0]     pins_s;
  logic           secondary_oscillator_s;
  logic           sclk_s;
  logic           posc_s;
  logic           sys_s;
  logic           ref_src;
  logic           ref_run;
  logic           ref_div_out;
  logic           osc_mode;
  logic           osc_want;
  logic           wr_en;
  logic           rd_en;
  logic           addr_ok;
  sorc_osc_stat_t stat;

  function automatic logic is_osc_code(input sorc_cfg_t c);
    is_osc_code = (c == SORC_CFG_NORMAL) || (c == SORC_CFG_LOWPWR);
  endfunction : is_osc_code

  function automatic logic addr_hit(input logic [11:0] a);
    addr_hit = (a == `SORC_REF_CTRL_OFF) || (a == `SORC_OSC_CTRL_OFF)
            || (a == `SORC_CONFIG_OFF) || (a == `SORC_STATUS_OFF);
  endfunction : addr_hit

  assign pins_raw = {secondary_oscillator_clk_in, slow_ext_clock_in, primary_osc_clk, sys_clk_in, 1'b0};

  sorc_sync #(.W(5)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (pins_raw),
    .dout    (pins_s)
  );

  assign secondary_oscillator_s = pins_s[4];
  assign sclk_s = pins_s[3];
  assign posc_s = pins_s[2];
  assign sys_s  = pins_s[1];

  // Bus decode
  assign pready  = 1'b1;
  assign addr_ok = addr_hit(apb_req.paddr);
  assign pslverr = apb_req.psel & apb_req.penable & ~addr_ok;
  assign wr_en   = apb_req.psel & apb_req.penable & apb_req.pwrite & addr_ok;
  assign rd_en   = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;

  // Oscillator mode decode
  assign osc_mode = is_osc_code(cfg);
  // Peripheral request or force-on starts the crystal; digital and spare modes ignore both
  assign osc_want = osc_mode & (periph_osc_req | force_on);

  // Register and status next state
  always_comb begin
    next_ref_out_control = ref_out_control;
    next_force_on        = force_on;
    next_keep_in_sleep   = keep_in_sleep;
    next_cfg             = cfg;
    if (wr_en) begin
      case (apb_req.paddr)
        `SORC_REF_CTRL_OFF: begin
          next_ref_out_control = apb_req.pwdata[15:0] & `SORC_REF_CTRL_WMASK;
        end
        `SORC_OSC_CTRL_OFF: begin
          next_force_on      = apb_req.pwdata[`SORC_FORCE_ON_BIT];
          next_keep_in_sleep = apb_req.pwdata[`SORC_KEEP_SLP_BIT];
        end
        `SORC_CONFIG_OFF: begin
          next_cfg = sorc_cfg_t'(apb_req.pwdata[`SORC_CFG_HI:`SORC_CFG_LO]);
        end
        default: begin
          next_cfg = cfg;
        end
      endcase
    end
  end

  assign stat = '{osc_enable: osc_want, low_power: secondary_oscillator_low_drive,
                  digital_pins: secondary_oscillator_pins_digital, stable: stable};

  always_comb begin
    next_prdata = prdata;
    if (rd_en) begin
      case (apb_req.paddr)
        `SORC_REF_CTRL_OFF: next_prdata = {16'h0000, ref_out_control};
        `SORC_OSC_CTRL_OFF: next_prdata = {29'h0, keep_in_sleep, force_on, 1'b0};
        `SORC_CONFIG_OFF:   next_prdata = {22'h0, cfg, 8'h00};
        `SORC_STATUS_OFF:   next_prdata = {28'h0, stat};
        default:            next_prdata = 32'h0000_0000;
      endcase
    end
  end

  // Start-up timer: stable only after the full count
  always_comb begin
    next_startup_cnt = startup_cnt;
    next_stable      = stable;
    if (!osc_want) begin
      next_startup_cnt = 32'h0;
      next_stable      = 1'b0;
    end else if (!stable) begin
      if (startup_cnt >= 32'(STARTUP_CYCLES - 1)) begin
        next_stable = 1'b1;
      end else begin
        next_startup_cnt = startup_cnt + 32'h1;
      end
    end
  end

  // Clock selection for peripherals and instruction clock
  always_comb begin
    next_prev_switch  = switch_done;
    next_instr_div    = instr_div;
    next_periph_clk_q = 1'b0;
    if (cfg == SORC_CFG_DIGITAL) begin
      next_periph_clk_q = sclk_s & periph_osc_req;
    end else if (stable) begin
      next_periph_clk_q = secondary_oscillator_s & periph_osc_req;
    end
    if (fosc_half_mode && sys_s && !instr_div) begin
      next_instr_div = 1'b1;
    end else if (fosc_half_mode && !sys_s && instr_div) begin
      next_instr_div = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_out_control <= `SORC_REF_CTRL_RESET;
      force_on        <= 1'b0;
      keep_in_sleep   <= 1'b0;
      cfg             <= sorc_cfg_t'(`SORC_CFG_RESET);
      prdata          <= 32'h0000_0000;
      startup_cnt     <= 32'h0;
      stable          <= 1'b0;
      prev_switch     <= 1'b0;
      instr_div       <= 1'b0;
      periph_clk_q    <= 1'b0;
      instr_clock_out <= 1'b0;
    end else begin
      ref_out_control <= next_ref_out_control;
      force_on        <= next_force_on;
      keep_in_sleep   <= next_keep_in_sleep;
      cfg             <= next_cfg;
      prdata          <= next_prdata;
      startup_cnt     <= next_startup_cnt;
      stable          <= next_stable;
      prev_switch     <= next_prev_switch;
      instr_div       <= next_instr_div;
      periph_clk_q    <= next_periph_clk_q;
      // Toggle on each rising sys edge halves the rate
      if (!fosc_half_mode) begin
        instr_clock_out <= 1'b0;
      end else if (sys_s && !instr_div) begin
        instr_clock_out <= ~instr_clock_out;
      end
    end
  end

  assign periph_osc_clk     = periph_clk_q;
  assign periph_osc_ready   = (cfg == SORC_CFG_DIGITAL) ? 1'b1 : stable;
  assign secondary_oscillator_crystal_drive = osc_want | (force_on & osc_mode & sys_clk_is_secondary_oscillator);
  assign secondary_oscillator_low_drive     = (cfg == SORC_CFG_LOWPWR);
  assign secondary_oscillator_pins_digital  = (cfg == SORC_CFG_DIGITAL);
  assign low_power_rc_osc_power         = low_power_rc_osc_keep;

  // Primary oscillator powered down in sleep unless kept
  assign primary_osc_power = ~sleep_mode | keep_in_sleep;

  // Reference source and run gating, independent of oscillator mode
  assign ref_src = ref_out_control[`SORC_REF_SEL_BIT] ? posc_s : sys_s;
  assign ref_run = ref_out_control[`SORC_REF_EN_BIT]
                 & (~sleep_mode | (ref_out_control[`SORC_REF_SLP_BIT]
                 & ref_out_control[`SORC_REF_SEL_BIT] & primary_osc_power));

  sorc_divider #(.DW(16)) u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .src     (ref_src),
    .run     (ref_run),
    .code    (ref_out_control[`SORC_REF_DIV_HI:`SORC_REF_DIV_LO]),
    .clk_out (ref_div_out)
  );

  assign ref_clock_pin    = ref_div_out & ref_run;
  assign ref_clock_pin_oe = ref_out_control[`SORC_REF_EN_BIT];
endmodule : sorc_top

// >>> sim/sorc_ref_sink.sv
// Purpose: External device clocked from the reference pin
// Assumes: Pin sampled on pclk, pin well below pclk rate
// Notes:   Counts rising edges while the pin is driven
`timescale 1ns/1ns
module sorc_ref_sink (
  input  wire logic pclk,
  input  wire logic clr,
  input  wire logic pin,
  input  wire logic oe,
  output int        rises
);
  logic last = 1'b0;
  always @(posedge pclk) begin
    last <= pin;
    if (clr) begin
      rises <= 0;
    end else if (oe && pin && !last) begin
      rises <= rises + 1;
    end
  end
endmodule : sorc_ref_sink

// >>> sim/sorc_top_assertions.sv
// Purpose: Port-level checks of sorc_top
// Assumes: Single clock domain
// Notes:   Attached by bind
`timescale 1ns/1ns
module sorc_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sleep_mode,
  input wire logic low_power_rc_osc_keep,
  input wire logic secondary_oscillator_crystal_drive,
  input wire logic secondary_oscillator_low_drive,
  input wire logic secondary_oscillator_pins_digital,
  input wire logic periph_osc_clk,
  input wire logic periph_osc_ready,
  input wire logic primary_osc_power,
  input wire logic low_power_rc_osc_power,
  input wire logic instr_clock_out,
  input wire logic ref_clock_pin,
  input wire logic ref_clock_pin_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_digital_no_drive: assert property (
    secondary_oscillator_pins_digital |-> !secondary_oscillator_crystal_drive) else $error("crystal driven in digital mode");
  chk_low_not_digital: assert property (
    secondary_oscillator_low_drive |-> !secondary_oscillator_pins_digital) else $error("low drive with digital pins");
  chk_primary_awake: assert property (
    !sleep_mode |-> primary_osc_power) else $error("primary off while awake");
  chk_low_power_rc_osc_follow: assert property (
    low_power_rc_osc_power == low_power_rc_osc_keep) else $error("low_power_rc_osc power wrong");
  chk_ref_quiet: assert property (
    !ref_clock_pin_oe |-> !ref_clock_pin) else $error("ref pin active while disabled");
  chk_clk_gated: assert property (
    (!periph_osc_ready)[*2] |-> !periph_osc_clk) else $error("clock before stable");
  chk_instr_half: assert property (
    $changed(instr_clock_out) |=> $stable(instr_clock_out)) else $error("instr clock too fast");
  chk_sleep_quiet: assert property (
    (sleep_mode && !primary_osc_power)[*4] |-> !ref_clock_pin) else $error("ref in sleep");
endmodule : sorc_checker
bind sorc_top sorc_checker i_chk (.pclk(pclk), .presetn(presetn), .sleep_mode(sleep_mode),
  .low_power_rc_osc_keep(low_power_rc_osc_keep), .secondary_oscillator_crystal_drive(secondary_oscillator_crystal_drive),
  .secondary_oscillator_low_drive(secondary_oscillator_low_drive), .secondary_oscillator_pins_digital(secondary_oscillator_pins_digital),
  .periph_osc_clk(periph_osc_clk), .periph_osc_ready(periph_osc_ready),
  .primary_osc_power(primary_osc_power), .low_power_rc_osc_power(low_power_rc_osc_power),
  .instr_clock_out(instr_clock_out), .ref_clock_pin(ref_clock_pin),
  .ref_clock_pin_oe(ref_clock_pin_oe));

// >>> sim/tb_top.sv
// Purpose: Self-checking bench for sorc_top
// Assumes: Start-up shortened to 20 cycles
// Notes:   Register access over APB tasks
`timescale 1ns/1ns
`include "sorc_regs.svh"
module tb_top;
  import sorc_pkg::*;
  localparam int SU = 20;
  logic          pclk = 1'b0;
  logic          presetn = 1'b0;
  sorc_apb_req_t req = '0;
  logic          preq = 1'b0, slw = 1'b0, posc = 1'b0, sys = 1'b0;
  logic          slp = 1'b0, half = 1'b0, lkeep = 1'b0, clr = 1'b0;
  logic          pready, pslverr, xdrv, lowd, pdig, pclko, prdy, ppwr, lpwr, iclk, rpin, roe;
  logic [31:0]   prdata, rd;
  logic          err;
  int            n_fail = 0, samples_checked = 0, sh = 4, cyc = 0, cnt, k;
  always #4 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc % sh == 0) sys <= ~sys;
    if (cyc % 8 == 0) posc <= ~posc;
    if (cyc % 16 == 0) slw <= ~slw;
  end
  sorc_top #(.STARTUP_CYCLES(SU)) i_dut (.pclk(pclk), .presetn(presetn), .apb_req(req),
    .pready(pready), .pslverr(pslverr), .prdata(prdata), .periph_osc_req(preq),
    .secondary_oscillator_clk_in(slw), .slow_ext_clock_in(slw), .primary_osc_clk(posc), .sys_clk_in(sys),
    .sys_clk_is_secondary_oscillator(1'b0), .switch_done(1'b0), .sleep_mode(slp), .fosc_half_mode(half),
    .low_power_rc_osc_keep(lkeep), .secondary_oscillator_crystal_drive(xdrv), .secondary_oscillator_low_drive(lowd),
    .secondary_oscillator_pins_digital(pdig), .periph_osc_clk(pclko), .periph_osc_ready(prdy),
    .primary_osc_power(ppwr), .low_power_rc_osc_power(lpwr), .instr_clock_out(iclk),
    .ref_clock_pin(rpin), .ref_clock_pin_oe(roe));
  sorc_ref_sink i_sink (.pclk(pclk), .clr(clr), .pin(rpin), .oe(roe), .rises(cnt));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int w = 0;
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      w++;
    end while (pready !== 1'b1 && w < 50);
    rd = prdata;
    err = pslverr;
    req <= '0;
  endtask : apb
  task automatic meas(input int exp);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    repeat (256) @(posedge pclk);
    check((cnt >= exp - 1 && cnt <= exp + 1) ? 32'(exp) : 32'(cnt), 32'(exp));
  endtask : meas
  task automatic wait_hi(ref logic s);
    for (k = 0; k < 3 * SU && s !== 1'b1; k++) @(posedge pclk);
  endtask : wait_hi
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    give_verdict();
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `SORC_REF_CTRL_OFF, 0);
    check(rd, 32'h0000_0000);
    apb(0, `SORC_CONFIG_OFF, 0);
    check(rd, 32'h0000_0300);
    apb(1, `SORC_REF_CTRL_OFF, 32'hFFFF_FFFF);
    apb(0, `SORC_REF_CTRL_OFF, 0);
    check(rd, 32'h0000_BF00);
    apb(1, `SORC_OSC_CTRL_OFF, 32'h2);
    for (int c = 0; c < 4; c++) begin
      apb(1, `SORC_CONFIG_OFF, 32'(c) << 8);
      @(posedge pclk);
      check(xdrv, c == 3 || c == 1);
      check(lowd, c == 1);
      check(pdig, c == 0);
    end
    $display("end of mode test");
    apb(1, `SORC_OSC_CTRL_OFF, 0);
    repeat (4) @(posedge pclk);
    preq <= 1'b1;
    repeat (2) @(posedge pclk);
    check(xdrv, 1);
    check(prdy, 0);
    wait_hi(prdy);
    check(k >= SU - 4 && k <= SU + 8, 1);
    apb(1, `SORC_CONFIG_OFF, 0);
    @(posedge pclk);
    check(prdy, 1);
    wait_hi(pclko);
    check(pclko, 1);
    preq <= 1'b0;
    $display("end of start-up test");
    apb(1, `SORC_REF_CTRL_OFF, 32'h8000);
    meas(32);
    apb(1, `SORC_REF_CTRL_OFF, 32'h8200);
    meas(8);
    apb(1, `SORC_REF_CTRL_OFF, 32'h9000);
    meas(16);
    apb(1, `SORC_REF_CTRL_OFF, 32'h8000);
    sh = 2;
    meas(64);
    sh = 4;
    apb(1, `SORC_REF_CTRL_OFF, 32'hB000);
    slp <= 1'b1;
    @(posedge pclk);
    check(ppwr, 0);
    meas(0);
    apb(1, `SORC_OSC_CTRL_OFF, 32'h4);
    @(posedge pclk);
    check(ppwr, 1);
    meas(16);
    apb(1, `SORC_REF_CTRL_OFF, 32'h9000);
    meas(0);
    slp <= 1'b0;
    apb(1, `SORC_REF_CTRL_OFF, 0);
    meas(0);
    check(roe, 0);
    $display("end of reference test");
    apb(0, 12'h010, 0);
    check(err, 1);
    check(rd, 0);
    half <= 1'b1;
    lkeep <= 1'b1;
    wait_hi(iclk);
    check(iclk, 1);
    check(lpwr, 1);
    $display("end of misc test");
    give_verdict();
  end
endmodule : tb_top
